// ===== bench/ctp_timer_pair_test.sv
// self-checking bench for the cascadable timer pair, register traffic over wishbone
// assumes ctp_regs.svh offsets and the one-cycle registered ack of the register file
`timescale 1ns/1ns
`default_nettype none
`include "ctp_regs.svh"

module ctp_timer_pair_test;
  // ----------------------------------------------------------------------------
  // stimulus and observation signals
  // ----------------------------------------------------------------------------
  logic        clk_i = 1'b0;      // 100 MHz system clock
  logic        rst_i = 1'b1;      // held for 12 cycles
  logic        cyc   = 1'b0;      // wishbone cycle
  logic        stb   = 1'b0;      // wishbone strobe
  logic        we    = 1'b0;      // write enable
  logic [5:0]  adr   = 6'h00;     // byte address
  logic [3:0]  sel   = 4'h0;      // byte lanes
  logic [31:0] dat   = 32'h0;     // write data
  logic        lfc   = 1'b0;      // low-frequency clock pulse
  logic [1:0]  pin   = 2'h3;      // count pins idle high, count on falling edge
  logic [31:0] rdat;              // data taken at the ack edge
  logic [31:0] rd_o;              // read data from the block
  logic        ack;               // acknowledge from the block
  logic [1:0]  pins;              // divider output pins
  logic        irq;               // level interrupt
  int          n_errors  = 0;     // mismatches
  int          tests_run = 0;     // comparisons
  int          n;                 // cycles spent in the last wait
  time         t1;                // first interrupt time
  time         t2;                // second interrupt time

  always #5 clk_i = ~clk_i;

  ctp_timer_pair uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd_o), .wb_ack_o(ack),
    .lfc_tick_i(lfc), .tc_pin_i(pin), .divider_output_pin_o(pins),
    .match_interrupt_o(irq)
  );

  // ----------------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------------
  task report_and_stop;
    if (n_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // one classic cycle; request held until ack is sampled high
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_errors++;
      $display("ERROR %0t no acknowledge", $time);
    end
    rdat = rd_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : xfer

  task wr(input logic [5:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task rd(input logic [5:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0);
    chk(rdat, exp, what);
  endtask : rd

  // bounded wait for the interrupt level
  task wait_irq(input int lim);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (irq !== 1'b1 && n < lim);
  endtask : wait_irq

  // time between two matches, status read clears in between
  task period(input int ticks, input logic [31:0] st);
    wait_irq(ticks + 20);
    t1 = $time;
    rd(`CTP_OFF_STATUS, st, "status");
    wait_irq(ticks + 20);
    t2 = $time;
    chk(32'(t2 - t1), 32'(ticks * 10), "match period");
  endtask : period

  // k pulses on the lower pin (p=1) or on the low-frequency clock (p=0)
  task tickp(input int p, input int k);
    repeat (k) begin
      @(posedge clk_i);
      if (p == 1) pin[0] <= 1'b0;
      else lfc <= 1'b1;
      @(posedge clk_i);
      lfc <= 1'b0;
      @(posedge clk_i);
      pin[0] <= 1'b1;
      repeat (2) @(posedge clk_i);
    end
  endtask : tickp

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'(pins), 32'h3, "pins after reset");
    chk(32'(irq), 32'h0, "irq after reset");
    // every register and one unmapped place read zero after reset
    for (int i = 0; i < 11; i++) rd(6'(i * 4), 32'h0, "reset value");
    wr(6'h28, 32'hff);
    rd(6'h28, 32'h0, "unmapped write");
    wr(`CTP_OFF_DIVSEL, 32'h1);
    rd(`CTP_OFF_DIVSEL, 32'h1, "divider tap readback");
    wr(`CTP_OFF_DIVSEL, 32'h0);
    // duty registers only store and read back in this block
    wr(`CTP_OFF_DUTY_HI, 32'h80);
    rd(`CTP_OFF_DUTY_HI, 32'h80, "duty readback");
    // 8-bit timer on the divide-by-8 tap, compare 10, flip-flop bit zero
    wr(`CTP_OFF_MASK, 32'h3);
    wr(`CTP_OFF_CMP_LO, 32'd10);
    wr(`CTP_OFF_CTRL_LO, 32'h38);
    period(10 * 8, 32'h1);
    wr(`CTP_OFF_CTRL_LO, 32'h0);
    rd(`CTP_OFF_COUNT, 32'h0, "stopped count");
    rd(`CTP_OFF_STATUS, 32'h1, "status sticky");
    rd(`CTP_OFF_STATUS, 32'h0, "status cleared");
    // upper unit alone, masked interrupt stays low while status sets
    wr(`CTP_OFF_MASK, 32'h1);
    wr(`CTP_OFF_CMP_HI, 32'd4);
    wr(`CTP_OFF_CTRL_HI, 32'h38);
    repeat (50) @(posedge clk_i);
    chk(32'(irq), 32'h0, "masked irq");
    rd(`CTP_OFF_STATUS, 32'h2, "upper status");
    wr(`CTP_OFF_MASK, 32'h3);
    wait_irq(40);
    chk(32'(irq), 32'h1, "unmasked irq");
    // control writes while running: run kept high is ignored, stop keeps fields
    wr(`CTP_OFF_CTRL_HI, 32'h0c);
    rd(`CTP_OFF_CTRL_HI, 32'h38, "running write");
    wr(`CTP_OFF_CTRL_HI, 32'h86);
    rd(`CTP_OFF_CTRL_HI, 32'h30, "stop write");
    rd(`CTP_OFF_COUNT, 32'h0, "stopped upper");
    wr(`CTP_OFF_CTRL_HI, 32'h0);
    xfer(1'b0, `CTP_OFF_STATUS, 32'h0);
    // cascade: lower 011 on divide-by-8 tap, upper 16-bit timer, compare 0x0102
    wr(`CTP_OFF_CTRL_LO, 32'h33);
    wr(`CTP_OFF_CMP_LO, 32'h02);
    wr(`CTP_OFF_CMP_HI, 32'h01);
    wr(`CTP_OFF_MASK, 32'h2);
    wr(`CTP_OFF_CTRL_HI, 32'h8c);
    repeat (2) @(posedge clk_i);
    chk(32'(pins), 32'h0, "cascade pins");
    period(258 * 8, 32'h2);
    wr(`CTP_OFF_CTRL_HI, 32'h0);
    wr(`CTP_OFF_CTRL_HI, 32'h0);
    wr(`CTP_OFF_CTRL_LO, 32'h0);
    // event sources: pin falling edges, then the low-frequency clock divided
    // by eight on tap code 0, compare 3
    for (int p = 1; p >= 0; p--) begin
      wr(`CTP_OFF_DIVSEL, 32'(1 - p));
      wr(`CTP_OFF_CMP_LO, 32'd3);
      wr(`CTP_OFF_MASK, 32'h1);
      xfer(1'b0, `CTP_OFF_STATUS, 32'h0);
      wr(`CTP_OFF_CTRL_LO, (p == 1) ? 32'h78 : 32'h08);
      tickp(p, (p == 1) ? 2 : 16);
      rd(`CTP_OFF_COUNT, 32'h2, "event count");
      chk(32'(irq), 32'h0, "no early match");
      tickp(p, (p == 1) ? 1 : 8);
      repeat (4) @(posedge clk_i);
      chk(32'(irq), 32'h1, "event match");
      rd(`CTP_OFF_COUNT, 32'h0, "cleared on match");
      wr(`CTP_OFF_CTRL_LO, 32'h0);
    end
    report_and_stop();
  end

  // ----------------------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    $display("ERROR %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule : ctp_timer_pair_test

`default_nettype wire

// ===== core/ctp_pkg.sv
// types used by the timer pair; its prescaler uses none of them
// assumes ctp_regs.svh holds the numeric layout
package ctp_pkg;

  // ----------------------------------------------------------------------------
  // operating mode field codes
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    CTP_M_TIMER8  = 3'h0,  // 8-bit timer or event counter
    CTP_M_DIV8    = 3'h1,  // divider output
    CTP_M_PWM8    = 3'h2,  // 8-bit pwm
    CTP_M_LOWER16 = 3'h3,  // reserved, lower unit of a cascade
    CTP_M_TIMER16 = 3'h4,  // 16-bit timer or event counter
    CTP_M_WARMUP  = 3'h5,  // warm-up counter
    CTP_M_PWM16   = 3'h6,  // 16-bit pwm
    CTP_M_PPG16   = 3'h7   // 16-bit pulse generation
  } ctp_mode_e;

  typedef logic [7:0] ctp_byte_t;  // one unit's 8-bit value

endpackage : ctp_pkg

// ===== core/ctp_prescaler.sv
// prescaler taps of high_freq_clock (clk_i) and low_freq_clock (tick input)
// assumes lfc_tick_i is a one-cycle pulse per low-frequency clock period
`timescale 1ns/1ns
`default_nettype none
`include "ctp_regs.svh"

module ctp_prescaler (
  input  wire logic   clk_i,       // high_freq_clock
  input  wire logic   rst_i,       // synchronous, active high
  input  wire logic   lfc_tick_i,  // low_freq_clock pulse
  ctp_tick_if.src     tk           // tap outputs
);

  logic [`CTP_FC_CNT_W-1:0] fc_cnt_q;  // free running high-freq divider
  logic [`CTP_FS_CNT_W-1:0] fs_cnt_q;  // low-freq divider by eight

  // ----------------------------------------------------------------------------
  // dividers
  // ----------------------------------------------------------------------------
  // both run from reset so the taps never wait on a start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fc_cnt_q <= '0;
    end else begin
      fc_cnt_q <= fc_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fs_cnt_q <= '0;
    end else if (lfc_tick_i) begin
      fs_cnt_q <= fs_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // taps: a divide by 2^k pulses when the low k bits are all ones
  // ----------------------------------------------------------------------------
  always_comb begin
    tk.tick[0] = tk.div_sel ? (lfc_tick_i && (&fs_cnt_q)) : (&fc_cnt_q[`CTP_DIV11_MSB:0]);
    tk.tick[1] = &fc_cnt_q[`CTP_DIV7_MSB:0];
    tk.tick[2] = &fc_cnt_q[`CTP_DIV5_MSB:0];
    tk.tick[3] = &fc_cnt_q[`CTP_DIV3_MSB:0];
    tk.tick[4] = lfc_tick_i;
    tk.tick[5] = fc_cnt_q[0];
    tk.tick[6] = 1'b1;  // fc itself: every cycle
  end

endmodule : ctp_prescaler

`default_nettype wire

// ===== core/ctp_regs.svh
// register offsets, field positions, reset values and counts of the timer pair
// assumes a 32-bit wishbone word per register, byte address in the offsets
`ifndef CTP_REGS_SVH
`define CTP_REGS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define CTP_OFF_CTRL_LO  6'h00
`define CTP_OFF_CTRL_HI  6'h04
`define CTP_OFF_CMP_LO   6'h08
`define CTP_OFF_CMP_HI   6'h0c
`define CTP_OFF_DUTY_LO  6'h10
`define CTP_OFF_DUTY_HI  6'h14
`define CTP_OFF_STATUS   6'h18
`define CTP_OFF_MASK     6'h1c
`define CTP_OFF_COUNT    6'h20
`define CTP_OFF_DIVSEL   6'h24

// ----------------------------------------------------------------------------
// unit control register fields
// ----------------------------------------------------------------------------
`define CTP_FF_BIT       7
`define CTP_CLK_MSB      6
`define CTP_CLK_LSB      4
`define CTP_RUN_BIT      3
`define CTP_MODE_MSB     2
`define CTP_MODE_LSB     0
`define CTP_MODE16_BIT   2

// ----------------------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------------------
`define CTP_CTRL_RST     8'h00
`define CTP_CMP_RST      8'h00
`define CTP_BYTE_ZERO    8'h00
`define CTP_BYTE_ONE     8'h01
`define CTP_BYTE_FULL    8'hff
`define CTP_WORD_ONE     16'h0001
`define CTP_PIN_SEL      3'h7
`define CTP_FC_CNT_W     11
`define CTP_FS_CNT_W     3
`define CTP_DIV11_MSB    10
`define CTP_DIV7_MSB     6
`define CTP_DIV5_MSB     4
`define CTP_DIV3_MSB     2

`endif

// ===== core/ctp_tick_if.sv
// carries the prescaler's count-enable taps to the timer pair
// assumes one clock domain, taps are one-cycle pulses
`timescale 1ns/1ns
`default_nettype none

interface ctp_tick_if;
  logic [6:0] tick;     // enable per clock-select code 0..6
  logic       div_sel;  // divider_tap_select: code 0 from low-freq tap

  modport src (input div_sel, output tick);
  modport dst (output div_sel, input tick);
endinterface : ctp_tick_if

`default_nettype wire

// ===== core/ctp_timer_pair.sv
// cascadable pair of 8-bit up-counting timers with a wishbone register file
// assumes a classic wishbone master, pin inputs synchronous to clk_i
`timescale 1ns/1ns
`default_nettype none
`include "ctp_regs.svh"

// How it works
// - stop write keeps mode, clock, flip-flop fields
// - 16-bit mode clocks upper from lower overflow
// - lower clock, upper run and flip-flop rule cascade
// - two units join as one 16-bit counter
// - 8-bit timer matches, interrupts, clears, restarts
// - compare register unbuffered, takes effect at once
// - mode field counts only for codes 0 and 4; bit 2 of the upper unit selects the cascade
module ctp_timer_pair (
  input  wire logic        clk_i,        // system clock, 100 MHz
  input  wire logic        rst_i,        // synchronous, active high
  input  wire logic        wb_cyc_i,     // wishbone cycle
  input  wire logic        wb_stb_i,     // wishbone strobe
  input  wire logic        wb_we_i,      // write enable
  input  wire logic [5:0]  wb_adr_i,     // byte address
  input  wire logic [3:0]  wb_sel_i,     // byte lanes
  input  wire logic [31:0] wb_dat_i,     // write data
  output logic      [31:0] wb_dat_o,     // read data
  output logic             wb_ack_o,     // acknowledge
  input  wire logic        lfc_tick_i,   // low_freq_clock pulse
  input  wire logic [1:0]  tc_pin_i,     // count pins, lower in bit 0
  output logic      [1:0]  divider_output_pin_o, // inverse of flip-flops
  output logic             match_interrupt_o     // level interrupt
);

  ctp_tick_if tk ();

  ctp_pkg::ctp_byte_t ctrl_q [2];  // unit_control_register per unit
  ctp_pkg::ctp_byte_t cmp_q  [2];  // compare_register per unit
  ctp_pkg::ctp_byte_t duty_q [2];  // duty_register per unit
  ctp_pkg::ctp_byte_t cnt_q  [2];  // up-counters
  logic [1:0]         status_q;    // sticky match flags
  logic [1:0]         mask_q;      // interrupt enables
  logic               div_sel_q;   // divider_tap_select
  logic [1:0]         pin_q;       // previous pin level for edge detect
  logic [1:0]         evt;         // match events this cycle
  logic [1:0]         tick_raw;    // selected count clock per unit
  logic [1:0]         en8;         // 8-bit timer count enable
  logic               mode16;      // upper unit in a 16-bit mode
  logic               en16;        // cascade count enable
  logic [15:0]        nxt16;       // cascade value after increment
  logic               hit16;       // cascade match
  logic               req;         // bus request present
  logic               fire;        // access completes this edge
  logic               rd_status;   // status read, clears flags

  // ----------------------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------------------
  assign tk.div_sel = div_sel_q;

  ctp_prescaler u_pre (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .lfc_tick_i (lfc_tick_i),
    .tk         (tk)
  );

  // ----------------------------------------------------------------------------
  // wishbone slave: ack one cycle after the request, write at the ack edge
  // ----------------------------------------------------------------------------
  assign req       = wb_cyc_i && wb_stb_i;
  assign fire      = req && wb_ack_o;
  assign rd_status = fire && !wb_we_i && (wb_adr_i == `CTP_OFF_STATUS);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req && !wb_ack_o;  // drops the cycle after it was given
    end
  end

  // read data sampled with the request, unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (req && !wb_ack_o) begin
      if (wb_adr_i == `CTP_OFF_CTRL_LO) begin
        wb_dat_o <= {24'h0, ctrl_q[0]};
      end else if (wb_adr_i == `CTP_OFF_CTRL_HI) begin
        wb_dat_o <= {24'h0, ctrl_q[1]};
      end else if (wb_adr_i == `CTP_OFF_CMP_LO) begin
        wb_dat_o <= {24'h0, cmp_q[0]};
      end else if (wb_adr_i == `CTP_OFF_CMP_HI) begin
        wb_dat_o <= {24'h0, cmp_q[1]};
      end else if (wb_adr_i == `CTP_OFF_DUTY_LO) begin
        wb_dat_o <= {24'h0, duty_q[0]};
      end else if (wb_adr_i == `CTP_OFF_DUTY_HI) begin
        wb_dat_o <= {24'h0, duty_q[1]};
      end else if (wb_adr_i == `CTP_OFF_STATUS) begin
        wb_dat_o <= {30'h0, status_q};
      end else if (wb_adr_i == `CTP_OFF_MASK) begin
        wb_dat_o <= {30'h0, mask_q};
      end else if (wb_adr_i == `CTP_OFF_COUNT) begin
        wb_dat_o <= {16'h0, cnt_q[1], cnt_q[0]};
      end else if (wb_adr_i == `CTP_OFF_DIVSEL) begin
        wb_dat_o <= {31'h0, div_sel_q};
      end else begin
        wb_dat_o <= '0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // mode decode and count enables
  // ----------------------------------------------------------------------------
  assign mode16 = ctrl_q[1][`CTP_MODE16_BIT];
  // lower clock select drives the cascade, upper run bit gates it
  assign en16   = mode16 && ctrl_q[1][`CTP_RUN_BIT] && tick_raw[0] &&
                  (ctrl_q[1][`CTP_MODE_MSB:`CTP_MODE_LSB] == ctp_pkg::CTP_M_TIMER16);
  // both counters and both compare registers form one word
  assign nxt16  = {cnt_q[1], cnt_q[0]} + `CTP_WORD_ONE;
  assign hit16  = (nxt16 == {cmp_q[1], cmp_q[0]});

  // interrupt of the upper unit belongs to the cascade
  assign evt[1] = en16 ? hit16 : (en8[1] && (cnt_q[1] + `CTP_BYTE_ONE == cmp_q[1]));
  assign evt[0] = en8[0] && (cnt_q[0] + `CTP_BYTE_ONE == cmp_q[0]);

  // ----------------------------------------------------------------------------
  // per-unit control, compare, duty, clock select and counter
  // ----------------------------------------------------------------------------
  for (genvar u = 0; u < 2; u++) begin : g_unit
    logic [5:0] off_ctrl;  // this unit's control offset
    logic [5:0] off_cmp;   // this unit's compare offset
    logic [5:0] off_duty;  // this unit's duty offset
    logic [2:0] csel;      // clock-select field
    logic       wr_ok;     // byte lane 0 write to this unit
    ctp_pkg::ctp_byte_t wd;

    assign off_ctrl = (u == 0) ? `CTP_OFF_CTRL_LO : `CTP_OFF_CTRL_HI;
    assign off_cmp  = (u == 0) ? `CTP_OFF_CMP_LO  : `CTP_OFF_CMP_HI;
    assign off_duty = (u == 0) ? `CTP_OFF_DUTY_LO : `CTP_OFF_DUTY_HI;
    assign csel     = ctrl_q[u][`CTP_CLK_MSB:`CTP_CLK_LSB];
    assign wr_ok    = fire && wb_we_i && wb_sel_i[0];
    assign wd       = wb_dat_i[7:0];

    // pin counts on its falling edge; the upper unit ignores its
    // select in a cascade since the lower overflow clocks it there
    assign tick_raw[u] = (csel == `CTP_PIN_SEL) ? (pin_q[u] && !tc_pin_i[u])
                                                : tk.tick[csel];
    assign en8[u] = !mode16 && ctrl_q[u][`CTP_RUN_BIT] && tick_raw[u] &&
                    (ctrl_q[u][`CTP_MODE_MSB:`CTP_MODE_LSB] == ctp_pkg::CTP_M_TIMER8);

    // control: a stop write only clears run; fields load while stopped
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ctrl_q[u] <= `CTP_CTRL_RST;
      end else if (wr_ok && (wb_adr_i == off_ctrl)) begin
        if (!ctrl_q[u][`CTP_RUN_BIT]) begin
          ctrl_q[u] <= wd;  // start may load all fields at once
        end else if (!wd[`CTP_RUN_BIT]) begin
          ctrl_q[u][`CTP_RUN_BIT] <= 1'b0;
        end
        // running and staying on: fields held, guards against
      end
    end

    // compare has no shadow: a write acts on the next compare
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cmp_q[u] <= `CTP_CMP_RST;
      end else if (wr_ok && (wb_adr_i == off_cmp)) begin
        cmp_q[u] <= wd;
      end
    end

    // duty is stored for the pwm modes, which this block leaves idle
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        duty_q[u] <= `CTP_CMP_RST;
      end else if (wr_ok && (wb_adr_i == off_duty)) begin
        duty_q[u] <= wd;
      end
    end

    // counter: stop clears, 8-bit match clears, cascade moves both bytes
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cnt_q[u] <= `CTP_BYTE_ZERO;
      end else if (!ctrl_q[mode16 ? 1 : u][`CTP_RUN_BIT]) begin
        cnt_q[u] <= `CTP_BYTE_ZERO;
      end else if (en16) begin
        cnt_q[u] <= hit16 ? `CTP_BYTE_ZERO : nxt16[u*8 +: 8];
      end else if (en8[u]) begin
        cnt_q[u] <= evt[u] ? `CTP_BYTE_ZERO : cnt_q[u] + `CTP_BYTE_ONE;
      end
    end

    // output pin shows the inverse of the flip-flop bit
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        divider_output_pin_o[u] <= 1'b1;
      end else begin
        divider_output_pin_o[u] <= !ctrl_q[(mode16 ? 1 : u)][`CTP_FF_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // pin history, tap select, status and mask
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q <= '0;
    end else begin
      pin_q <= tc_pin_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_sel_q <= 1'b0;
      mask_q    <= '0;
    end else if (fire && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == `CTP_OFF_DIVSEL) begin
        div_sel_q <= wb_dat_i[0];
      end else if (wb_adr_i == `CTP_OFF_MASK) begin
        mask_q <= wb_dat_i[1:0];
      end
    end
  end

  // a match in the same cycle as the clearing read survives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= '0;
    end else begin
      status_q <= (rd_status ? 2'b00 : status_q) | evt;
    end
  end

  assign match_interrupt_o = |(status_q & mask_q);

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  stop_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(ctrl_q[0][`CTP_RUN_BIT]) && !mode16 |=> cnt_q[0] == `CTP_BYTE_ZERO)
    else $error("stop did not clear counter");
  stop_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(ctrl_q[1][`CTP_RUN_BIT]) |->
    ctrl_q[1][`CTP_FF_BIT:`CTP_CLK_LSB] == $past(ctrl_q[1][`CTP_FF_BIT:`CTP_CLK_LSB]) &&
    ctrl_q[1][`CTP_MODE_MSB:`CTP_MODE_LSB] == $past(ctrl_q[1][`CTP_MODE_MSB:`CTP_MODE_LSB]))
    else $error("stop changed fields");
  match8_a: assert property (@(posedge clk_i) disable iff (rst_i)
    evt[0] |=> cnt_q[0] == `CTP_BYTE_ZERO && status_q[0])
    else $error("8-bit match not handled");
  cascade_hi_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en16 && !hit16 && cnt_q[0] != `CTP_BYTE_FULL |=> $stable(cnt_q[1]))
    else $error("upper moved without overflow");
  cascade_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en16 && !hit16 && cnt_q[0] == `CTP_BYTE_FULL |=>
    cnt_q[1] == $past(cnt_q[1]) + `CTP_BYTE_ONE) else $error("overflow lost");
  match16_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en16 && hit16 |=> {cnt_q[1], cnt_q[0]} == 16'h0000 && status_q[1])
    else $error("16-bit match not handled");
  set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_status && evt[1] |=> status_q[1]) else $error("event lost on clear");
  // the interrupt may only rise after a match or a register write
  irq_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(match_interrupt_o) |-> $past(|evt) || $past(fire && wb_we_i))
    else $error("interrupt rose without cause");
  cmp_now_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && wb_we_i && wb_sel_i[0] && wb_adr_i == `CTP_OFF_CMP_LO |=>
    cmp_q[0] == $past(wb_dat_i[7:0])) else $error("compare write delayed");

endmodule : ctp_timer_pair

`default_nettype wire
